// *** testbench/isa_host_model.sv ***
// Host model that issues byte-wide I/O cycles on the Avalon slave port.
`timescale 1ns/1ps
`default_nettype none

module isa_host_model (
    input wire logic i_clk_sys,
    output logic [9:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest
);
    initial begin
        o_address = 10'h000;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h00000000;
        o_byteenable = 4'h0;
    end

    // The request is held until waitrequest is sampled low. Released lines
    // carry inverted values so a stale address or byte is never mistaken.
    task automatic cycle(input logic [9:0] a, input logic [7:0] d,
                         input logic [3:0] be, input logic rd,
                         output logic [7:0] q);
        @(posedge i_clk_sys);
        o_address <= a;
        o_writedata <= {24'h000000, d};
        o_byteenable <= be;
        o_read <= rd;
        o_write <= ~rd;
        @(posedge i_clk_sys);
        while (i_waitrequest !== 1'b0) begin
            @(posedge i_clk_sys);
        end
        q = i_readdata[7:0];
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~{24'h000000, d};
    endtask

    // Both key writes go out back to back with nothing in between.
    task automatic unlock(input logic [9:0] port);
        logic [7:0] q;
        cycle(port, 8'h44, 4'h1, 1'b0, q);
        cycle(port, 8'h44, 4'h1, 1'b0, q);
    endtask

    task automatic lock(input logic [9:0] port);
        logic [7:0] q;
        cycle(port, 8'hAA, 4'h1, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// *** testbench/strap_config_unlock_tb.sv ***
// Self-checking testbench for strap capture, decode and configuration unlock.
`timescale 1ns/1ps
`default_nettype none
`include "strap_unlock_cfg.svh"
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))

module strap_config_unlock_tb;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] st_lpt = 2'h0, st_mode = 2'h0, st_ua = 2'h0, st_ub = 2'h0;
    logic [1:0] st_disk = 2'h0, st_fl = 2'h0;
    logic [9:0] address;
    logic read, write, waitrequest;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic o_straps_valid, o_lpt_en, o_uart_a_en, o_uart_b_en, o_disk_if_en;
    logic o_disk_if_sec, o_floppy_en, o_floppy_sec, o_efm2_en, o_cfg_mode;
    logic o_data_rate_pins_oe;
    logic [9:0] o_lpt_base, o_uart_a_base, o_cfg_index_addr;
    logic [1:0] o_lpt_mode, o_uart_b_sel;
    int n_mismatch = 0;
    int check_count = 0;

    always #20 i_clk_sys = ~i_clk_sys;

    strap_config_unlock u_strap_config_unlock (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
        .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
        .i_lpt_addr_strap_hi(st_lpt[1]), .i_lpt_addr_strap_lo(st_lpt[0]),
        .i_lpt_extcap_strap(st_mode[1]), .i_lpt_enhanced_strap(st_mode[0]),
        .i_uart_a_addr_strap_hi(st_ua[1]), .i_uart_a_addr_strap_lo(st_ua[0]),
        .i_uart_b_addr_strap_hi(st_ub[1]), .i_uart_b_addr_strap_lo(st_ub[0]),
        .i_disk_if_enable_strap(st_disk[1]), .i_disk_if_addr_strap(st_disk[0]),
        .i_floppy_ctrl_strap(st_fl[1]), .i_floppy_addr_strap(st_fl[0]),
        .o_straps_valid(o_straps_valid), .o_lpt_en(o_lpt_en),
        .o_lpt_base(o_lpt_base), .o_lpt_mode(o_lpt_mode),
        .o_uart_a_en(o_uart_a_en), .o_uart_a_base(o_uart_a_base),
        .o_uart_b_en(o_uart_b_en), .o_uart_b_sel(o_uart_b_sel),
        .o_disk_if_en(o_disk_if_en), .o_disk_if_sec(o_disk_if_sec),
        .o_floppy_en(o_floppy_en), .o_floppy_sec(o_floppy_sec),
        .o_efm2_en(o_efm2_en), .o_data_rate_pins_oe(o_data_rate_pins_oe),
        .o_cfg_mode(o_cfg_mode), .o_cfg_index_addr(o_cfg_index_addr)
    );

    isa_host_model u_isa_host_model (
        .i_clk_sys(i_clk_sys), .o_address(address), .o_read(read),
        .o_write(write), .o_writedata(writedata), .o_byteenable(byteenable),
        .i_readdata(readdata), .i_waitrequest(waitrequest)
    );

    task automatic check_val(input string nm, input logic [31:0] e, g);
        check_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        logic [7:0] q;
        u_isa_host_model.cycle(a, d, be, 1'b0, q);
    endtask

    task automatic rd_chk(input string nm, input logic [9:0] a,
                          input logic [7:0] e);
        logic [7:0] q;
        u_isa_host_model.cycle(a, 8'h00, 4'h1, 1'b1, q);
        `CHK(nm, e, q);
    endtask

    // The register updates at the completion edge, so look one edge later.
    task automatic mode_chk(input logic e);
        @(posedge i_clk_sys);
        `CHK("cfg_mode", e, o_cfg_mode);
    endtask

    task automatic restart(input logic [1:0] k, input logic [1:0] fl);
        @(posedge i_clk_sys);
        i_rstn <= 1'b0;
        st_lpt <= k;
        st_mode <= k;
        st_ua <= k;
        st_ub <= k;
        st_disk <= k;
        st_fl <= fl;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        `CHK("straps_valid", 1'b1, o_straps_valid);
    endtask

    task automatic check_decode(input logic [1:0] k, input logic [1:0] fl);
        logic [9:0] lb[4] = '{10'h000, `LPT_BASE_1, `LPT_BASE_2, `LPT_BASE_3};
        logic [9:0] ub[4] = '{10'h000, `UART_A_BASE_1, `UART_A_BASE_2,
                              `UART_A_BASE_3};
        logic [9:0] ix;
        ix = (fl == 2'b01) ? `CFG_INDEX_SEC : `CFG_INDEX_PRI;
        `CHK("lpt_en", k != 2'b00, o_lpt_en);
        `CHK("lpt_base", lb[k], o_lpt_base);
        `CHK("lpt_mode", k, o_lpt_mode);
        `CHK("uart_a_en", k != 2'b00, o_uart_a_en);
        `CHK("uart_a_base", ub[k], o_uart_a_base);
        `CHK("uart_b_en", k != 2'b00, o_uart_b_en);
        `CHK("uart_b_sel", k, o_uart_b_sel);
        `CHK("disk_if_en", k[1], o_disk_if_en);
        `CHK("disk_if_sec", k == 2'b11, o_disk_if_sec);
        `CHK("floppy_en", fl[1], o_floppy_en);
        `CHK("floppy_sec", fl == 2'b11, o_floppy_sec);
        `CHK("rate_oe", fl[1], o_data_rate_pins_oe);
        `CHK("efm2_en", 1'b0, o_efm2_en);
        `CHK("index_addr", ix, o_cfg_index_addr);
    endtask

    task automatic t_straps;
        for (int i = 0; i < 4; i++) begin
            restart(2'(i), 2'(i));
            check_decode(2'(i), 2'(i));
        end
        st_lpt <= 2'b00;
        st_mode <= 2'b00;
        st_fl <= 2'b00;
        repeat (3) @(posedge i_clk_sys);
        check_decode(2'b11, 2'b11);
        $display("test t_straps done");
    endtask

    task automatic t_unlock;
        restart(2'b01, 2'b01);
        u_isa_host_model.unlock(`CFG_INDEX_PRI);
        mode_chk(1'b0);
        u_isa_host_model.unlock(`CFG_INDEX_SEC);
        mode_chk(1'b1);
        wr(`CFG_INDEX_SEC, 8'h06);
        wr(`CFG_DATA_SEC, 8'h5A);
        rd_chk("cr6", `CFG_DATA_SEC, 8'h5A);
        rd_chk("index", `CFG_INDEX_SEC, 8'h06);
        wr(`CFG_INDEX_SEC, 8'h01);
        wr(`CFG_DATA_SEC, 8'hFF);
        rd_chk("cr1", `CFG_DATA_SEC, 8'hF5);
        `CHK("lpt_base", `LPT_BASE_1, o_lpt_base);
        wr(`CFG_INDEX_SEC, 8'h00);
        wr(`CFG_DATA_SEC, 8'h08);
        wr(`CFG_INDEX_SEC, 8'h03);
        wr(`CFG_DATA_SEC, 8'h02);
        wr(`CFG_INDEX_SEC, 8'h05);
        wr(`CFG_DATA_SEC, 8'h01);
        // The last register write lands at the completion edge; let it settle.
        @(posedge i_clk_sys);
        `CHK("floppy_en", 1'b1, o_floppy_en);
        `CHK("efm2_en", 1'b1, o_efm2_en);
        `CHK("floppy_sec", 1'b1, o_floppy_sec);
        u_isa_host_model.lock(`CFG_INDEX_SEC);
        mode_chk(1'b0);
        rd_chk("closed", `CFG_DATA_SEC, 8'h00);
        $display("test t_unlock done");
    endtask

    task automatic t_break;
        restart(2'b11, 2'b00);
        wr(`CFG_INDEX_PRI, 8'h44);
        wr(10'h2F8, 8'h00);
        wr(`CFG_INDEX_PRI, 8'h44);
        mode_chk(1'b0);
        wr(`CFG_INDEX_PRI, 8'h44);
        mode_chk(1'b1);
        u_isa_host_model.lock(`CFG_INDEX_PRI);
        wr(`CFG_INDEX_PRI, 8'h44);
        wr(`CFG_INDEX_PRI, 8'h44, 4'h0);
        wr(`CFG_INDEX_PRI, 8'h44);
        mode_chk(1'b0);
        rd_chk("unmapped", 10'h2F8, 8'h00);
        wr(`CFG_INDEX_PRI, 8'h44);
        mode_chk(1'b1);
        rd_chk("index", `CFG_INDEX_PRI, 8'h00);
        u_isa_host_model.lock(`CFG_INDEX_PRI);
        mode_chk(1'b0);
        $display("test t_break done");
    endtask

    task automatic t_locked;
        restart(2'b10, 2'b11);
        u_isa_host_model.unlock(`CFG_INDEX_PRI);
        mode_chk(1'b1);
        wr(`CFG_INDEX_PRI, 8'h00);
        wr(`CFG_DATA_PRI, 8'h00);
        wr(`CFG_INDEX_PRI, 8'h03);
        wr(`CFG_DATA_PRI, 8'h02);
        rd_chk("cr3", `CFG_DATA_PRI, 8'h00);
        `CHK("floppy_en", 1'b1, o_floppy_en);
        `CHK("efm2_en", 1'b0, o_efm2_en);
        `CHK("floppy_sec", 1'b1, o_floppy_sec);
        u_isa_host_model.lock(`CFG_INDEX_PRI);
        $display("test t_locked done");
    endtask

    initial begin
        repeat (5000) @(posedge i_clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        t_straps();
        t_unlock();
        t_break();
        t_locked();
        summarize();
    end
endmodule
`default_nettype wire

// *** verilog/cfg_key_detect.sv ***
// Two-write key detector that opens and closes configuration mode.
`timescale 1ns/1ps
`default_nettype none
`include "strap_unlock_cfg.svh"

module cfg_key_detect (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_wr_fire,
    input wire logic i_wr_index,
    input wire logic [7:0] i_wr_data,
    output logic o_cfg_mode,
    output logic o_armed
);

    strap_unlock_pkg::key_state_t state;
    strap_unlock_pkg::key_state_t next_state;

    wire logic enter_key = i_wr_fire & i_wr_index & (i_wr_data == `KEY_ENTER);
    wire logic exit_key = i_wr_fire & i_wr_index & (i_wr_data == `KEY_EXIT);

    // Any completed write that is not the key breaks an armed sequence.
    always_comb begin
        next_state = state;
        case (state)
            strap_unlock_pkg::KEY_IDLE: begin
                if (enter_key) begin
                    next_state = strap_unlock_pkg::KEY_ARMED;
                end
            end
            strap_unlock_pkg::KEY_ARMED: begin
                if (enter_key) begin
                    next_state = strap_unlock_pkg::KEY_OPEN;
                end else if (i_wr_fire) begin
                    next_state = strap_unlock_pkg::KEY_IDLE;
                end
            end
            strap_unlock_pkg::KEY_OPEN: begin
                if (exit_key) begin
                    next_state = strap_unlock_pkg::KEY_IDLE;
                end
            end
            default: begin
                next_state = strap_unlock_pkg::KEY_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= strap_unlock_pkg::KEY_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign o_cfg_mode = (state == strap_unlock_pkg::KEY_OPEN);
    assign o_armed = (state == strap_unlock_pkg::KEY_ARMED);

    property p_armed_cause;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_armed) |-> $past(enter_key);
    endproperty
    a_armed_cause: assert property (p_armed_cause)
        else $error("Detector armed without a key write.");

    property p_open_needs_two;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(o_cfg_mode) |-> $past(o_armed) && $past(enter_key);
    endproperty
    a_open_needs_two: assert property (p_open_needs_two)
        else $error("Configuration mode opened without two key writes.");

endmodule
`default_nettype wire

// *** verilog/strap_config_unlock.sv ***
// Strap capture, strap decode and configuration unlock with register access.
//
// Notes on behaviour
// - Parallel address straps: off, 3BC, 378, 278.
// - Mode straps select printer, EPP, ECP, ECP+EPP.
// - Primary serial straps: off, 3E8, 2F8, 3F8.
// - Disk straps: off, reserved, primary, secondary.
// - Floppy strap high: fixed address, rate pins driven.
// - Floppy strap low: disabled, inputs, software override.
// - Index port 3F0 or 370, data next.
// - Strap-set fields ignore software writes.
// - Two back-to-back 44H index writes unlock.
// - Any other write between breaks unlock.
// - AAH to index port leaves configuration.
// - Straps caught after reset, held until reset.
// - Relocated: registers 0-F through port 371H.
// - Access needs configuration mode and loaded index.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "strap_unlock_cfg.svh"

module strap_config_unlock (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_lpt_addr_strap_hi,
    input wire logic i_lpt_addr_strap_lo,
    input wire logic i_lpt_extcap_strap,
    input wire logic i_lpt_enhanced_strap,
    input wire logic i_uart_a_addr_strap_hi,
    input wire logic i_uart_a_addr_strap_lo,
    input wire logic i_uart_b_addr_strap_hi,
    input wire logic i_uart_b_addr_strap_lo,
    input wire logic i_disk_if_enable_strap,
    input wire logic i_disk_if_addr_strap,
    input wire logic i_floppy_ctrl_strap,
    input wire logic i_floppy_addr_strap,
    output logic o_straps_valid,
    output logic o_lpt_en,
    output logic [9:0] o_lpt_base,
    output logic [1:0] o_lpt_mode,
    output logic o_uart_a_en,
    output logic [9:0] o_uart_a_base,
    output logic o_uart_b_en,
    output logic [1:0] o_uart_b_sel,
    output logic o_disk_if_en,
    output logic o_disk_if_sec,
    output logic o_floppy_en,
    output logic o_floppy_sec,
    output logic o_efm2_en,
    output logic o_data_rate_pins_oe,
    output logic o_cfg_mode,
    output logic [9:0] o_cfg_index_addr
);

    // Strap image, caught once in the first clock after reset release.
    logic captured;
    logic [1:0] lpt_addr_q;
    logic [1:0] lpt_mode_q;
    logic [1:0] uart_a_q;
    logic [1:0] uart_b_q;
    logic [1:0] disk_if_q;
    logic floppy_ctrl_q;
    logic floppy_addr_q;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            captured <= 1'b0;
            lpt_addr_q <= 2'h0;
            lpt_mode_q <= 2'h0;
            uart_a_q <= 2'h0;
            uart_b_q <= 2'h0;
            disk_if_q <= 2'h0;
            floppy_ctrl_q <= 1'b0;
            floppy_addr_q <= 1'b0;
        end else if (!captured) begin
            captured <= 1'b1;
            lpt_addr_q <= {i_lpt_addr_strap_hi, i_lpt_addr_strap_lo};
            lpt_mode_q <= {i_lpt_extcap_strap, i_lpt_enhanced_strap};
            uart_a_q <= {i_uart_a_addr_strap_hi, i_uart_a_addr_strap_lo};
            uart_b_q <= {i_uart_b_addr_strap_hi, i_uart_b_addr_strap_lo};
            disk_if_q <= {i_disk_if_enable_strap, i_disk_if_addr_strap};
            floppy_ctrl_q <= i_floppy_ctrl_strap;
            floppy_addr_q <= i_floppy_addr_strap;
        end
    end

    assign o_straps_valid = captured;

    // Strap decode for the fixed peripheral settings.
    assign o_lpt_en = (lpt_addr_q != 2'h0);
    assign o_lpt_base = (lpt_addr_q == 2'h1) ? `LPT_BASE_1 :
                        (lpt_addr_q == 2'h2) ? `LPT_BASE_2 :
                        (lpt_addr_q == 2'h3) ? `LPT_BASE_3 : 10'h000;
    assign o_lpt_mode = lpt_mode_q;
    assign o_uart_a_en = (uart_a_q != 2'h0);
    assign o_uart_a_base = (uart_a_q == 2'h1) ? `UART_A_BASE_1 :
                           (uart_a_q == 2'h2) ? `UART_A_BASE_2 :
                           (uart_a_q == 2'h3) ? `UART_A_BASE_3 :
                           10'h000;
    assign o_uart_b_en = (uart_b_q != 2'h0);
    assign o_uart_b_sel = uart_b_q;
    // The reserved disk code keeps the interface off rather than guessing.
    assign o_disk_if_en = disk_if_q[1];
    assign o_disk_if_sec = disk_if_q[1] & disk_if_q[0];

    // The index port only moves when software owns the floppy settings.
    wire logic relocated = ~floppy_ctrl_q & floppy_addr_q;
    wire logic [9:0] index_addr = relocated ? `CFG_INDEX_SEC
                                            : `CFG_INDEX_PRI;
    wire logic [9:0] data_addr = relocated ? `CFG_DATA_SEC
                                           : `CFG_DATA_PRI;
    assign o_cfg_index_addr = index_addr;

    // Avalon slave: one wait cycle, then the answer with registered data.
    logic ack_q;
    logic [7:0] rdata_q;
    logic [7:0] cfg_index;
    logic cfg_mode;
    logic armed;

    wire logic req = i_avs_read | i_avs_write;
    wire logic wr_fire = i_avs_write & ack_q;
    wire logic low_lane = i_avs_byteenable[0];
    wire logic [7:0] wbyte = i_avs_writedata[7:0];
    wire logic idx_hit = (i_avs_address == index_addr);
    wire logic data_hit = (i_avs_address == data_addr);
    wire logic idx_valid = (cfg_index[7:4] == 4'h0);
    wire logic data_open = cfg_mode & idx_valid;
    wire logic data_wr = wr_fire & low_lane & data_hit & data_open;
    wire logic index_wr = wr_fire & low_lane & idx_hit & cfg_mode &
                          (wbyte != `KEY_EXIT);

    assign o_avs_waitrequest = ~(req & ack_q);
    assign o_avs_readdata = {24'h000000, rdata_q};

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q & captured;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_index <= `INDEX_RESET;
        end else if (index_wr) begin
            cfg_index <= wbyte;
        end
    end

    // Key writes count only on byte lane 0, but a write on any other lane still breaks them.
    cfg_key_detect u_key (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_wr_fire(wr_fire),
        .i_wr_index(idx_hit & low_lane),
        .i_wr_data(wbyte),
        .o_cfg_mode(cfg_mode),
        .o_armed(armed)
    );
    assign o_cfg_mode = cfg_mode;

    // Strap view and lock masks for the registers that mirror straps.
    wire logic fdc_sw = ~floppy_ctrl_q;
    logic [7:0] cfg_reg [`NUM_CFG_REGS];
    logic [7:0] lock_vec [`NUM_CFG_REGS];
    logic [7:0] img_vec [`NUM_CFG_REGS];
    logic [7:0] cfg_view [`NUM_CFG_REGS];
    logic [`NUM_CFG_REGS-1:0] reg_we;

    wire logic [7:0] lock0 = (8'h01 << `CR0_IDE_EN) |
                             (floppy_ctrl_q ? (8'h01 << `CR0_FLOPPY_EN)
                                            : 8'h00);
    wire logic [7:0] img0 = ({7'h00, o_disk_if_en} << `CR0_IDE_EN) |
                            ({7'h00, floppy_ctrl_q} << `CR0_FLOPPY_EN);
    wire logic [7:0] img1 = ({6'h00, lpt_addr_q} << `CR1_LPT_ADDR_LSB) |
                            ({6'h00, lpt_mode_q} << `CR1_LPT_MODE_LSB);
    wire logic [7:0] img2 = ({6'h00, uart_a_q} << `CR2_UART_A_LSB) |
                            ({6'h00, uart_b_q} << `CR2_UART_B_LSB);
    wire logic [7:0] lock3 = floppy_ctrl_q ? (8'h01 << `CR3_EFM2)
                                           : 8'h00;
    wire logic [7:0] lock5 = (8'h01 << `CR5_IDE_SEC) |
                             (floppy_ctrl_q ? (8'h01 << `CR5_FLOPPY_SEC)
                                            : 8'h00);
    wire logic [7:0] img5 = ({7'h00, floppy_addr_q} << `CR5_FLOPPY_SEC) |
                            ({7'h00, o_disk_if_sec} << `CR5_IDE_SEC);

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CFG_REGS; gi++) begin : g_reg
            localparam logic [3:0] IDX = 4'(gi);
            assign lock_vec[gi] =
                (IDX == `CR_CTRL0) ? lock0 :
                (IDX == `CR_CTRL1) ? `LOCK_STRAP_FIELDS :
                (IDX == `CR_CTRL2) ? `LOCK_STRAP_FIELDS :
                (IDX == `CR_CTRL3) ? lock3 :
                (IDX == `CR_CTRL5) ? lock5 : 8'h00;
            assign img_vec[gi] =
                (IDX == `CR_CTRL0) ? img0 :
                (IDX == `CR_CTRL1) ? img1 :
                (IDX == `CR_CTRL2) ? img2 :
                (IDX == `CR_CTRL5) ? img5 : 8'h00;
            assign reg_we[gi] = data_wr & (cfg_index[3:0] == IDX);
            assign cfg_view[gi] = (cfg_reg[gi] & ~lock_vec[gi]) |
                                  (img_vec[gi] & lock_vec[gi]);
            // Locked bits keep their stored value; the view shows straps.
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    cfg_reg[gi] <= `CR_RESET;
                end else if (reg_we[gi]) begin
                    cfg_reg[gi] <= (cfg_reg[gi] & lock_vec[gi]) |
                                   (wbyte & ~lock_vec[gi]);
                end
            end
        end
    endgenerate

    // Floppy settings: strap-fixed, or software-owned with a safe power-up.
    wire logic [7:0] cr0 = cfg_reg[`CR_CTRL0];
    wire logic [7:0] cr3 = cfg_reg[`CR_CTRL3];
    wire logic [7:0] cr5 = cfg_reg[`CR_CTRL5];
    assign o_floppy_en = floppy_ctrl_q |
                         cr0[`CR0_FLOPPY_EN];
    assign o_floppy_sec = floppy_ctrl_q ? floppy_addr_q
                                        : cr5[`CR5_FLOPPY_SEC];
    assign o_efm2_en = fdc_sw & cr3[`CR3_EFM2];
    assign o_data_rate_pins_oe = captured & floppy_ctrl_q;

    // Read path: index port shows the index, data port the selected view.
    wire logic [7:0] read_mux =
        idx_hit ? (cfg_mode ? cfg_index : 8'h00) :
        (data_hit & data_open) ? cfg_view[cfg_index[3:0]] : 8'h00;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 8'h00;
        end else if (i_avs_read & ~ack_q) begin
            rdata_q <= read_mux;
        end
    end

    property p_answer_latency;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        captured && req && !ack_q |=> !o_avs_waitrequest;
    endproperty
    a_answer_latency: assert property (p_answer_latency)
        else $error("Bus request not answered after one wait cycle.");

    property p_unlock;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        armed && wr_fire && low_lane && idx_hit && wbyte == `KEY_ENTER
        |=> cfg_mode;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Second key write did not open configuration mode.");

    property p_break;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        armed && wr_fire && !(low_lane && idx_hit && wbyte == `KEY_ENTER)
        |=> !cfg_mode && !armed;
    endproperty
    a_break: assert property (p_break)
        else $error("Intervening write did not cancel the unlock.");

    property p_exit;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        cfg_mode && wr_fire && low_lane && idx_hit && wbyte == `KEY_EXIT
        |=> !cfg_mode ##1 !cfg_mode;
    endproperty
    a_exit: assert property (p_exit)
        else $error("Exit key did not close configuration mode.");

    property p_no_write_locked;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !cfg_mode |-> reg_we == '0;
    endproperty
    a_no_write_locked: assert property (p_no_write_locked)
        else $error("Register written outside configuration mode.");

    property p_straps_hold;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        captured |=> $stable(lpt_addr_q) && $stable(floppy_ctrl_q) &&
                     $stable(uart_a_q) && $stable(disk_if_q) && captured;
    endproperty
    a_straps_hold: assert property (p_straps_hold)
        else $error("Caught strap value changed before reset.");

    property p_lpt_decode;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_lpt_en |-> (o_lpt_base == `LPT_BASE_2) == (lpt_addr_q == 2'h2);
    endproperty
    a_lpt_decode: assert property (p_lpt_decode)
        else $error("Parallel base does not follow the address straps.");

    property p_index_place;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!floppy_ctrl_q && floppy_addr_q) == (o_cfg_index_addr == 10'h370);
    endproperty
    a_index_place: assert property (p_index_place)
        else $error("Index port at the wrong address.");

    property p_floppy_fixed;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        captured && floppy_ctrl_q |-> o_floppy_en && o_data_rate_pins_oe &&
            !o_efm2_en && (o_floppy_sec == floppy_addr_q);
    endproperty
    a_floppy_fixed: assert property (p_floppy_fixed)
        else $error("Strap-fixed floppy settings violated.");

    property p_floppy_soft;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !floppy_ctrl_q |-> !o_data_rate_pins_oe;
    endproperty
    a_floppy_soft: assert property (p_floppy_soft)
        else $error("Rate pins driven while software owns the floppy.");

    property p_index_frozen;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !cfg_mode |=> $stable(cfg_index);
    endproperty
    a_index_frozen: assert property (p_index_frozen)
        else $error("Index register moved outside configuration mode.");

    c_unlock: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(cfg_mode));
    c_break: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        armed ##1 (!armed && !cfg_mode));
    c_reg_write: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        data_wr);
    c_relocated_write: cover property (@(posedge i_clk_sys)
        disable iff (!i_rstn) relocated && data_wr);

endmodule
`default_nettype wire

// *** verilog/strap_unlock_cfg.svh ***
// Addresses, keys, field positions and reset values of the strap unlock block.
`ifndef STRAP_UNLOCK_CFG_SVH
`define STRAP_UNLOCK_CFG_SVH

`define IO_ADDR_W 10
`define CFG_INDEX_PRI 10'h3F0
`define CFG_INDEX_SEC 10'h370
`define CFG_DATA_PRI 10'h3F1
`define CFG_DATA_SEC 10'h371

`define KEY_ENTER 8'h44
`define KEY_EXIT 8'hAA

`define LPT_BASE_1 10'h3BC
`define LPT_BASE_2 10'h378
`define LPT_BASE_3 10'h278
`define UART_A_BASE_1 10'h3E8
`define UART_A_BASE_2 10'h2F8
`define UART_A_BASE_3 10'h3F8

`define NUM_CFG_REGS 16
`define CR_RESET 8'h00
`define INDEX_RESET 8'h00

`define CR_CTRL0 4'h0
`define CR_CTRL1 4'h1
`define CR_CTRL2 4'h2
`define CR_CTRL3 4'h3
`define CR_CTRL5 4'h5

`define CR0_IDE_EN 0
`define CR0_FLOPPY_EN 3
`define CR1_LPT_ADDR_LSB 0
`define CR1_LPT_MODE_LSB 2
`define CR2_UART_A_LSB 0
`define CR2_UART_B_LSB 2
`define CR3_EFM2 1
`define CR5_FLOPPY_SEC 0
`define CR5_IDE_SEC 1

`define LOCK_STRAP_FIELDS 8'h0F

`endif

// *** verilog/strap_unlock_pkg.sv ***
// Types shared by the strap unlock block.
package strap_unlock_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_OPEN
    } key_state_t;

    typedef enum logic [1:0] {
        LPT_PRINTER,
        LPT_EPP,
        LPT_ECP,
        LPT_ECP_EPP
    } lpt_mode_t;

endpackage
